//--- hw/timer_toggle_pkg.sv
// Package with register map, field layouts and constants of the toggle-output timer.
package timer_toggle_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the special-function-register bus
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_FOUR_CONTROL_ADDR = 8'hC8;
  localparam logic [7:0] TIMER_FIVE_CONTROL_ADDR = 8'h91;
  localparam logic [7:0] TIMER_FOUR_CONFIG_ADDR = 8'hC9;
  localparam logic [7:0] TIMER_FIVE_CONFIG_ADDR = 8'h96;
  localparam logic [7:0] TIMER_FOUR_CAP_LOW_ADDR = 8'hCA;
  localparam logic [7:0] TIMER_FOUR_CAP_HIGH_ADDR = 8'hCB;
  localparam logic [7:0] TIMER_FOUR_COUNT_LOW_ADDR = 8'hCC;
  localparam logic [7:0] TIMER_FOUR_COUNT_HIGH_ADDR = 8'hCD;

  // ----------------------------------------------------------------
  // Field layouts and reset values
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wrap_flag;
    logic ext_event_flag;
    logic [1:0] reserved;
    logic ext_input_enable;
    logic run_bit;
    logic count_source_select;
    logic capture_reload_select;
  } timer_control_t;

  typedef struct packed {
    logic [2:0] reserved;
    logic [1:0] clock_mode_field;
    logic toggle_state_bit;
    logic square_output_enable;
    logic decrement_enable;
  } timer_config_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  localparam timer_control_t CONTROL_RESET = '0;
  localparam timer_config_t CONFIG_RESET = '0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Clock modes and prescaler counts
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SYS_DIV12 = 2'h0;
  localparam logic [1:0] MODE_SYS = 2'h1;
  localparam logic [1:0] MODE_EXT_DIV8 = 2'h2;
  localparam logic [1:0] MODE_SYS_DIV2 = 2'h3;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic PIN_IDLE = 1'b1;

endpackage

//--- hw/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
module pin_sync (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_pin,
  output logic o_level,
  output logic o_fall,
  output logic o_rise
);

  logic s1, s2, s3;
  logic next_level, next_fall, next_rise;

  // A change counts only once the second and third stages agree.
  always_comb begin
    next_level = o_level;
    next_fall = 1'b0;
    next_rise = 1'b0;
    if (s2 == s3) begin
      next_level = s3;
      next_fall = o_level & ~s3;
      next_rise = ~o_level & s3;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1 <= timer_toggle_pkg::PIN_IDLE;
      s2 <= timer_toggle_pkg::PIN_IDLE;
      s3 <= timer_toggle_pkg::PIN_IDLE;
      o_level <= timer_toggle_pkg::PIN_IDLE;
      o_fall <= 1'b0;
      o_rise <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      o_level <= next_level;
      o_fall <= next_fall;
      o_rise <= next_rise;
    end
  end

endmodule

//--- hw/timer_prescaler.sv
// Timer clock prescaler producing one-cycle count enables per clock mode.
module timer_prescaler (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [1:0] i_mode,
  input wire logic i_ext_rise,
  output logic o_tick
);

  logic [3:0] div12, next_div12;
  logic div2, next_div2;
  logic [2:0] div8, next_div8;
  logic next_tick;

  always_comb begin
    next_div12 = (div12 == timer_toggle_pkg::DIV12_LAST) ? 4'h0 : div12 + 4'h1;
    next_div2 = ~div2;
    next_div8 = i_ext_rise ? div8 + 3'h1 : div8;
    unique case (i_mode)
      timer_toggle_pkg::MODE_SYS_DIV12: next_tick = (div12 == timer_toggle_pkg::DIV12_LAST);
      timer_toggle_pkg::MODE_SYS: next_tick = 1'b1;
      timer_toggle_pkg::MODE_EXT_DIV8: next_tick = i_ext_rise && (div8 == timer_toggle_pkg::DIV8_LAST);
      timer_toggle_pkg::MODE_SYS_DIV2: next_tick = div2;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div12 <= 4'h0;
      div2 <= 1'b0;
      div8 <= 3'h0;
      o_tick <= 1'b0;
    end else begin
      div12 <= next_div12;
      div2 <= next_div2;
      div8 <= next_div8;
      o_tick <= next_tick;
    end
  end

endmodule

//--- hw/timer_toggle_output.sv
// Sixteen-bit up/down timer with capture, reload and square-wave toggle output.
//
// Contract
// - On each overflow or underflow the toggle level inverts, giving 50% duty.
// - Down-counting in reload mode underflows at the reload value, then loads 0xFFFF.
// - Up-counting in reload mode overflows past 0xFFFF, then loads the reload value.
// - The pin carries the square wave only with output enable, reload mode, timer selection.
// - Writing 1 to the run bit starts counting and toggling.
// - The toggle-state bit reads the present level; writing forces it.
// - Square-wave frequency is timer clock over twice (65536 minus reload value).
// - The wrap flag in bit 7 sets when counting rolls 0xFFFF to 0x0000.
// - The wrap flag also sets on underflow in reload and capture modes.
// - A set wrap flag requests the interrupt; only software clears it.
// - The external flag in bit 6 sets on an enabled edge capture or reload.
// - With external-input enable 0, external falling edges are ignored; the input level still steers direction.
// - In capture mode an enabled falling edge copies the counter to capture registers.
// - In reload mode, decrement off, an enabled falling edge reloads and sets the flag.
// - In reload mode with decrement on, the input level sets direction, no reloads.
// - Capture/reload select 0 is reload mode, 1 is capture mode.
// - Run bit 0 stops the counter, 1 lets it count.
// - Decrement enable 0 forces up; 1 counts down on low input, up on high.
// - Clock mode selects system/12, system, external/8, system/2.
module timer_toggle_output #(
  parameter logic [7:0] CONTROL_ADDR = timer_toggle_pkg::TIMER_FOUR_CONTROL_ADDR,
  parameter logic [7:0] CONFIG_ADDR = timer_toggle_pkg::TIMER_FOUR_CONFIG_ADDR,
  parameter logic [7:0] CAP_LOW_ADDR = timer_toggle_pkg::TIMER_FOUR_CAP_LOW_ADDR,
  parameter logic [7:0] CAP_HIGH_ADDR = timer_toggle_pkg::TIMER_FOUR_CAP_HIGH_ADDR,
  parameter logic [7:0] COUNT_LOW_ADDR = timer_toggle_pkg::TIMER_FOUR_COUNT_LOW_ADDR,
  parameter logic [7:0] COUNT_HIGH_ADDR = timer_toggle_pkg::TIMER_FOUR_COUNT_HIGH_ADDR
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_ext_trigger_pin,
  input wire logic i_count_pin,
  input wire logic i_ext_clk,
  output logic o_toggle_pin,
  output logic o_toggle_oe,
  output logic o_timer_irq
);

  // ----------------------------------------------------------------
  // Bus request and decode
  // ----------------------------------------------------------------
  timer_toggle_pkg::sfr_req_t req;
  assign req = '{wr: i_sfr_wr, rd: i_sfr_rd, addr: i_sfr_addr, wdata: i_sfr_wdata};

  logic ctrl_wr, cfg_wr, cap_lo_wr, cap_hi_wr, cnt_lo_wr, cnt_hi_wr, cnt_wr, cap_wr;
  assign ctrl_wr = req.wr && (req.addr == CONTROL_ADDR);
  assign cfg_wr = req.wr && (req.addr == CONFIG_ADDR);
  assign cap_lo_wr = req.wr && (req.addr == CAP_LOW_ADDR);
  assign cap_hi_wr = req.wr && (req.addr == CAP_HIGH_ADDR);
  assign cnt_lo_wr = req.wr && (req.addr == COUNT_LOW_ADDR);
  assign cnt_hi_wr = req.wr && (req.addr == COUNT_HIGH_ADDR);
  assign cnt_wr = cnt_lo_wr || cnt_hi_wr;
  assign cap_wr = cap_lo_wr || cap_hi_wr;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  timer_toggle_pkg::timer_control_t ctrl, next_ctrl;
  timer_toggle_pkg::timer_config_t cfg, next_cfg;
  logic [15:0] count, next_count;
  logic [15:0] cap, next_cap;
  logic [7:0] next_rdata;
  logic next_pin, next_oe;

  // ----------------------------------------------------------------
  // Pin synchronisers and prescaler
  // ----------------------------------------------------------------
  logic ext_level, ext_fall, cnt_fall, eclk_rise, pre_tick;

  pin_sync u_ext_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_ext_trigger_pin),
    .o_level(ext_level),
    .o_fall(ext_fall),
    .o_rise()
  );

  pin_sync u_count_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_count_pin),
    .o_level(),
    .o_fall(cnt_fall),
    .o_rise()
  );

  pin_sync u_eclk_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_pin(i_ext_clk),
    .o_level(),
    .o_fall(),
    .o_rise(eclk_rise)
  );

  timer_prescaler u_prescaler (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_mode(cfg.clock_mode_field),
    .i_ext_rise(eclk_rise),
    .o_tick(pre_tick)
  );

  // ----------------------------------------------------------------
  // Count events
  // ----------------------------------------------------------------
  logic reload_mode, count_up, tick, ext_ev, wrap_up, wrap_down, wrap;
  assign reload_mode = ~ctrl.capture_reload_select;
  assign count_up = ~cfg.decrement_enable | ext_level;
  assign tick = ctrl.run_bit && (ctrl.count_source_select ? cnt_fall : pre_tick);
  // With decrement on in reload mode the input only steers direction.
  assign ext_ev = ctrl.ext_input_enable && ext_fall && !(reload_mode && cfg.decrement_enable);
  assign wrap_up = tick && count_up && (count == timer_toggle_pkg::COUNT_MAX);
  assign wrap_down = tick && !count_up &&
    (count == (reload_mode ? cap : timer_toggle_pkg::COUNT_MIN));
  assign wrap = wrap_up || wrap_down;

  // ----------------------------------------------------------------
  // Counter and capture/reload value
  // ----------------------------------------------------------------
  always_comb begin
    next_count = count;
    next_cap = cap;
    if (ext_ev && reload_mode) begin
      next_count = cap;
    end else if (wrap_up) begin
      next_count = reload_mode ? cap : timer_toggle_pkg::COUNT_MIN;
    end else if (wrap_down) begin
      next_count = timer_toggle_pkg::COUNT_MAX;
    end else if (tick) begin
      next_count = count_up ? count + timer_toggle_pkg::COUNT_ONE
                            : count - timer_toggle_pkg::COUNT_ONE;
    end
    if (ext_ev && !reload_mode) begin
      next_cap = count;
    end
    // Software writes win over hardware updates of the same byte.
    if (cnt_lo_wr) begin
      next_count[7:0] = req.wdata;
    end
    if (cnt_hi_wr) begin
      next_count[15:8] = req.wdata;
    end
    if (cap_lo_wr) begin
      next_cap[7:0] = req.wdata;
    end
    if (cap_hi_wr) begin
      next_cap[15:8] = req.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= timer_toggle_pkg::COUNT_RESET;
      cap <= timer_toggle_pkg::COUNT_RESET;
    end else begin
      count <= next_count;
      cap <= next_cap;
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_cfg = cfg;
    if (ctrl_wr) begin
      next_ctrl = timer_toggle_pkg::timer_control_t'(req.wdata);
      next_ctrl.reserved = 2'h0;
    end
    // Hardware sets win over a software clear in the same cycle.
    next_ctrl.wrap_flag = next_ctrl.wrap_flag | wrap;
    next_ctrl.ext_event_flag = next_ctrl.ext_event_flag | ext_ev;
    if (wrap) begin
      next_cfg.toggle_state_bit = ~cfg.toggle_state_bit;
    end
    // A forced level takes effect even if a wrap lands in the same cycle.
    if (cfg_wr) begin
      next_cfg = timer_toggle_pkg::timer_config_t'(req.wdata);
      next_cfg.reserved = 3'h0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl <= timer_toggle_pkg::CONTROL_RESET;
      cfg <= timer_toggle_pkg::CONFIG_RESET;
    end else begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Read data and pin outputs
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = o_sfr_rdata;
    if (req.rd) begin
      if (req.addr == CONTROL_ADDR) begin
        next_rdata = ctrl;
      end else if (req.addr == CONFIG_ADDR) begin
        next_rdata = cfg;
      end else if (req.addr == CAP_LOW_ADDR) begin
        next_rdata = cap[7:0];
      end else if (req.addr == CAP_HIGH_ADDR) begin
        next_rdata = cap[15:8];
      end else if (req.addr == COUNT_LOW_ADDR) begin
        next_rdata = count[7:0];
      end else if (req.addr == COUNT_HIGH_ADDR) begin
        next_rdata = count[15:8];
      end else begin
        next_rdata = timer_toggle_pkg::BYTE_ZERO;
      end
    end
    next_oe = cfg.square_output_enable && reload_mode && !ctrl.count_source_select;
    next_pin = next_oe && cfg.toggle_state_bit;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sfr_rdata <= timer_toggle_pkg::BYTE_ZERO;
      o_toggle_pin <= 1'b0;
      o_toggle_oe <= 1'b0;
    end else begin
      o_sfr_rdata <= next_rdata;
      o_toggle_pin <= next_pin;
      o_toggle_oe <= next_oe;
    end
  end

  assign o_timer_irq = ctrl.wrap_flag;

  // ----------------------------------------------------------------
  // Half-period monitor
  // ----------------------------------------------------------------
  // Counts ticks between wraps so that the square-wave period can be held against the reload value.
  // A period is clean only when nothing but ticks moved the counter since the previous wrap.
  logic [15:0] ticks_seen, next_ticks_seen;
  logic period_clean, next_period_clean, period_upset;
  assign period_upset = cnt_wr || cap_wr || ctrl_wr || cfg_wr || ext_ev || !count_up || !reload_mode;

  always_comb begin
    next_ticks_seen = ticks_seen;
    next_period_clean = (wrap || period_clean) && !period_upset;
    if (wrap) begin
      next_ticks_seen = timer_toggle_pkg::COUNT_RESET;
    end else if (tick) begin
      next_ticks_seen = ticks_seen + timer_toggle_pkg::COUNT_ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ticks_seen <= timer_toggle_pkg::COUNT_RESET;
      period_clean <= 1'b0;
    end else begin
      ticks_seen <= next_ticks_seen;
      period_clean <= next_period_clean;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_wrap_sets_flag: assert property (wrap |=> ctrl.wrap_flag && o_timer_irq)
    else $error("wrap did not set the wrap flag");
  a_flag_sticky: assert property (ctrl.wrap_flag && !ctrl_wr |=> ctrl.wrap_flag)
    else $error("wrap flag cleared without software");
  a_toggle_on_wrap: assert property (wrap && !cfg_wr |=> cfg.toggle_state_bit != $past(cfg.toggle_state_bit))
    else $error("toggle level did not invert on wrap");
  a_down_loads_max: assert property (wrap_down && !cnt_wr && !ext_ev |=> count == timer_toggle_pkg::COUNT_MAX)
    else $error("underflow did not load all ones");
  a_up_loads_cap: assert property (wrap_up && reload_mode && !cnt_wr && !ext_ev |=> count == $past(cap))
    else $error("overflow did not load reload value");
  a_pin_gated: assert property (!(cfg.square_output_enable && reload_mode && !ctrl.count_source_select)
    |=> !o_toggle_pin && !o_toggle_oe)
    else $error("pin driven while output disabled");
  a_stop_holds: assert property (!ctrl.run_bit && !cnt_wr && !ext_ev |=> count == $past(count))
    else $error("stopped counter moved");
  a_ext_ignored: assert property (!ctrl.ext_input_enable && !ctrl_wr && !cap_wr
    |=> $stable(ctrl.ext_event_flag) && $stable(cap))
    else $error("external edge acted while disabled");
  a_capture_copy: assert property (ext_ev && !reload_mode && !cap_wr |=> cap == $past(count))
    else $error("capture did not copy counter");
  a_step_one: assert property (tick && count_up && !wrap && !cnt_wr && !ext_ev
    |=> count == $past(count) + timer_toggle_pkg::COUNT_ONE)
    else $error("counter did not step by one");
  a_toggle_read: assert property (req.rd && req.addr == CONFIG_ADDR
    |=> o_sfr_rdata[2] == $past(cfg.toggle_state_bit))
    else $error("toggle state read mismatch");

  // External input, direction control, capture wrap, the wrap flag, the half-period length and the pin path.
  a_ext_sets_flag: assert property (ext_ev |=> ctrl.ext_event_flag)
    else $error("external event did not set its flag");
  a_ext_reload: assert property (ext_ev && reload_mode && !cnt_wr |=> count == $past(cap))
    else $error("external edge did not reload the counter");
  a_dir_only: assert property (reload_mode && cfg.decrement_enable && !ctrl_wr
    |=> $stable(ctrl.ext_event_flag))
    else $error("external input acted beyond direction control");
  a_step_down: assert property (tick && !count_up && !wrap && !cnt_wr && !ext_ev
    |=> count == $past(count) - timer_toggle_pkg::COUNT_ONE)
    else $error("counter did not step down by one");
  a_pin_follows: assert property (cfg.square_output_enable && reload_mode && !ctrl.count_source_select
    |=> o_toggle_oe && o_toggle_pin == $past(cfg.toggle_state_bit))
    else $error("pin does not show the toggle level");
  a_capture_wrap: assert property (wrap_up && !reload_mode && !cnt_wr && !ext_ev
    |=> count == timer_toggle_pkg::COUNT_MIN)
    else $error("capture overflow did not roll to zero");
  a_down_flag: assert property (wrap_down |=> ctrl.wrap_flag)
    else $error("underflow did not set the wrap flag");
  a_flag_needs_wrap: assert property (!ctrl.wrap_flag && !wrap && !ctrl_wr |=> !ctrl.wrap_flag)
    else $error("wrap flag set without a wrap");
  a_period_len: assert property (wrap_up && period_clean
    |-> ticks_seen == timer_toggle_pkg::COUNT_MAX - cap)
    else $error("half period does not match the reload value");

  c_wrap_seen: cover property (wrap ##1 ctrl.wrap_flag);
  c_ext_reload: cover property (ext_ev && reload_mode);
  c_pin_toggles: cover property (o_toggle_oe && $rose(o_toggle_pin));
  c_down_underflow: cover property (wrap_down && reload_mode);
  c_capture_taken: cover property (ext_ev && !reload_mode ##1 ctrl.ext_event_flag);

endmodule

//--- tb/pin_partner.sv
// Model of the port pins around the timer: trigger input, count input and external clock.
module pin_partner (
  input wire logic i_clk,
  output logic o_trigger_pin,
  output logic o_count_pin,
  output logic o_ext_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  logic ext_clk_on = 1'b0;
  logic [1:0] phase = 2'b00;

  // The external clock stands low unless a test asks for it. It runs at a quarter of the system
  // clock so that each level lasts two cycles and survives the agreement filter of the synchroniser.
  always @(posedge i_clk) begin
    phase <= phase + 2'b01;
  end
  assign o_ext_clk = ext_clk_on & phase[1];

  initial begin
    o_trigger_pin = 1'b1;
    o_count_pin = 1'b1;
  end

  task automatic set_ext_clk(input logic v);
    ext_clk_on = v;
  endtask

  // Pins are driven as clean digital levels, held long enough for the synchroniser.
  task automatic set_level(input logic v);
    @(posedge i_clk);
    o_trigger_pin <= v;
    repeat (6) @(posedge i_clk);
  endtask

  task automatic fall_trigger();
    set_level(1'b0);
    set_level(1'b1);
  endtask

  task automatic pulse_count(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_count_pin <= 1'b0;
      repeat (5) @(posedge i_clk);
      o_count_pin <= 1'b1;
      repeat (5) @(posedge i_clk);
    end
  endtask
endmodule

//--- tb/testbench.sv
// Self-checking testbench of the toggle-output timer through its register strobes.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [7:0] CTRL = timer_toggle_pkg::TIMER_FOUR_CONTROL_ADDR;
  localparam logic [7:0] CFG = timer_toggle_pkg::TIMER_FOUR_CONFIG_ADDR;
  localparam logic [7:0] CAP = timer_toggle_pkg::TIMER_FOUR_CAP_LOW_ADDR;
  localparam logic [7:0] CNT = timer_toggle_pkg::TIMER_FOUR_COUNT_LOW_ADDR;

  logic clk, rst_b, sfr_wr, sfr_rd, trig, cnt_pin, ext_clk;
  logic [7:0] sfr_addr, sfr_wdata, rdata, d, lo;
  logic toggle_pin, toggle_oe, timer_irq;
  logic [7:0] rate_exp [4] = '{8'h08, 8'h62, 8'h03, 8'h31};
  int err_count, n_compared, n;

  timer_toggle_output u_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_sfr_wr(sfr_wr), .i_sfr_rd(sfr_rd),
    .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata), .o_sfr_rdata(rdata),
    .i_ext_trigger_pin(trig), .i_count_pin(cnt_pin), .i_ext_clk(ext_clk),
    .o_toggle_pin(toggle_pin), .o_toggle_oe(toggle_oe), .o_timer_irq(timer_irq)
  );

  pin_partner u_pins (.i_clk(clk), .o_trigger_pin(trig), .o_count_pin(cnt_pin), .o_ext_clk(ext_clk));

  // ----------------------------------------------------------------
  // Register access and comparison helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= v;
    @(posedge clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk(d, exp, what);
  endtask

  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask

  // Counts settled cycles until the toggle pin changes level.
  task automatic half_period(output int c);
    logic v;
    c = 0;
    v = toggle_pin;
    while (toggle_pin === v && c < 100) begin
      @(posedge clk);
      #1 c++;
    end
  endtask

  task automatic oe_case(input logic [7:0] ctrl, input logic [7:0] cfg, input logic exp);
    wr(CTRL, ctrl);
    wr(CFG, cfg);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, toggle_oe}, {7'h00, exp}, "output enable");
  endtask

  task automatic test_done();
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // The sequence needs about 800 cycles; 25 times that means a hang.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    test_done();
  end

  initial begin
    rst_b = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    err_count = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(CTRL, 8'h00, "control reset");
    rd_chk(CFG, 8'h00, "config reset");
    chk({5'h00, toggle_pin, toggle_oe, timer_irq}, 8'h00, "outputs after reset");
    // Square wave: reload three below the top gives four ticks per half period.
    wr(CFG, 8'h0A);
    wr16(CAP, 16'hFFFC);
    wr16(CNT, 16'hFFFE);
    wr(CTRL, 8'h04);
    half_period(n);
    chk({7'h00, n < 100}, 8'h01, "toggling started");
    half_period(n);
    chk(8'(n), 8'h04, "half period");
    half_period(n);
    chk(8'(n), 8'h04, "second half period");
    chk({6'h00, toggle_oe, timer_irq}, 8'h03, "enable and request");
    rd_chk(CTRL, 8'h84, "wrap flag set");
    wr(CTRL, 8'h80);
    rd_chk(CTRL, 8'h80, "flag kept while stopped");
    wr(CTRL, 8'h00);
    rd_chk(CTRL, 8'h00, "flag cleared by software");
    chk({7'h00, timer_irq}, 8'h00, "request dropped");
    rd_chk(CFG, {5'b00001, toggle_pin, 2'b10}, "toggle state read");
    wr(CFG, 8'h0E);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, toggle_pin}, 8'h01, "toggle forced high");
    wr(CFG, 8'h0A);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, toggle_pin}, 8'h00, "toggle forced low");
    oe_case(8'h01, 8'h0A, 1'b0);
    oe_case(8'h02, 8'h0A, 1'b0);
    oe_case(8'h00, 8'h08, 1'b0);
    oe_case(8'h00, 8'h0A, 1'b1);
    // Up-count wrap in reload mode lands on the reload value.
    wr(CFG, 8'h08);
    wr16(CAP, 16'h1234);
    wr16(CNT, 16'hFFFE);
    wr(CTRL, 8'h04);
    repeat (6) @(posedge clk);
    rd_chk(CTRL, 8'h84, "overflow flag");
    wr(CTRL, 8'h00);
    rd_chk(CNT + 8'h01, 8'h12, "count after overflow");
    wr16(CNT, 16'hFFFE);
    wr(CTRL, 8'h05);
    repeat (6) @(posedge clk);
    rd_chk(CTRL, 8'h85, "capture overflow flag");
    wr(CTRL, 8'h01);
    rd_chk(CNT + 8'h01, 8'h00, "count after capture overflow");
    // Down-count with the trigger pin low underflows at the reload value.
    wr(CFG, 8'h09);
    u_pins.set_level(1'b0);
    wr16(CAP, 16'h1000);
    wr16(CNT, 16'h1002);
    wr(CTRL, 8'h04);
    repeat (6) @(posedge clk);
    rd_chk(CTRL, 8'h84, "underflow flag");
    wr(CTRL, 8'h00);
    rd_chk(CNT + 8'h01, 8'hFF, "count after underflow");
    u_pins.set_level(1'b1);
    // Clock modes: rate over a fixed run window, then the count must hold.
    for (int m = 0; m < 4; m++) begin
      wr(CFG, {3'b000, 2'(m), 3'b000});
      wr16(CNT, 16'h0000);
      u_pins.set_ext_clk(m == 2);
      wr(CTRL, 8'h04);
      repeat (96) @(posedge clk);
      wr(CTRL, 8'h00);
      rd(CNT);
      lo = d;
      // The /12 and external /8 modes start at an unknown prescaler phase, so only the system and system/2 modes match exactly.
      if (m % 2 == 1) begin
        chk(lo, rate_exp[m], "exact rate");
      end
      chk({7'h00, int'(lo) + 2 >= int'(rate_exp[m]) && int'(lo) <= int'(rate_exp[m]) + 2}, 8'h01, "rate");
      repeat (10) @(posedge clk);
      rd_chk(CNT, lo, "count held while stopped");
    end
    u_pins.set_ext_clk(1'b0);
    wr(CFG, 8'h00);
    wr16(CNT, 16'h0000);
    wr(CTRL, 8'h06);
    u_pins.pulse_count(5);
    wr(CTRL, 8'h00);
    rd_chk(CNT, 8'h05, "counter mode edges");
    // External trigger events.
    wr(CTRL, 8'h09);
    wr16(CNT, 16'hABCD);
    u_pins.fall_trigger();
    rd_chk(CAP, 8'hCD, "capture low");
    rd_chk(CAP + 8'h01, 8'hAB, "capture high");
    rd_chk(CTRL, 8'h49, "capture flag");
    wr(CTRL, 8'h01);
    wr16(CNT, 16'h5555);
    u_pins.fall_trigger();
    rd_chk(CAP, 8'hCD, "ignored edge");
    rd_chk(CTRL, 8'h01, "no flag when disabled");
    wr(CTRL, 8'h08);
    wr16(CAP, 16'h2222);
    wr16(CNT, 16'h7777);
    u_pins.fall_trigger();
    rd_chk(CNT + 8'h01, 8'h22, "edge reload");
    rd_chk(CTRL, 8'h48, "reload flag");
    wr(CTRL, 8'h08);
    wr(CFG, 8'h01);
    wr16(CNT, 16'h7777);
    u_pins.fall_trigger();
    rd_chk(CNT + 8'h01, 8'h77, "no reload with decrement");
    rd_chk(CTRL, 8'h08, "no flag with decrement");
    wr(8'h7F, 8'h55);
    rd_chk(8'h7F, 8'h00, "unmapped read");
    wr(CTRL, 8'h30);
    rd_chk(CTRL, 8'h00, "reserved bits");
    test_done();
  end
endmodule
